// [rtl/parallel_io_line_controller.sv]
// Programmable I/O line controller with a classic Wishbone register slave.
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`include "pio_params.svh"
module parallel_io_line_controller #(
    parameter int N = 32,
    parameter logic [31:0] HAS_PERIPH = 32'hFFFF_FFFF,
    parameter logic [31:0] OWNER_RESET = 32'hFFFF_FFFF
) (
    input wire logic clk_i, // System clock, 125 MHz.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic cyc_i, // Wishbone cycle.
    input wire logic stb_i, // Wishbone strobe.
    input wire logic we_i, // Wishbone write enable.
    input wire logic [`PIO_ADDR_W-1:0] adr_i, // Byte address.
    input wire logic [3:0] sel_i, // Byte lane selects.
    input wire logic [31:0] dat_i, // Write data.
    output logic [31:0] dat_o, // Read data.
    output logic ack_o, // Wishbone acknowledge.
    input wire logic [N-1:0] pad_in_i, // Pin levels from the pads.
    output logic [N-1:0] pad_out_o, // Level driven to the pads.
    output logic [N-1:0] pad_oe_n_o, // Pad drive enable, low drives.
    output logic [N-1:0] pullup_on_o, // Pull-up enable per pad.
    input wire logic [N-1:0] pa_out_i, // Peripheral A output level.
    input wire logic [N-1:0] pa_oe_i, // Peripheral A drive enable.
    input wire logic [N-1:0] pb_out_i, // Peripheral B output level.
    input wire logic [N-1:0] pb_oe_i, // Peripheral B drive enable.
    output logic [N-1:0] periph_in_o, // Pin level to both peripherals.
    output logic irq_o // Change interrupt, active high.
);
    localparam logic [N-1:0] MUXED = HAS_PERIPH[N-1:0];
    localparam logic [N-1:0] OWN_RST = OWNER_RESET[N-1:0] | ~MUXED;

    // Pad synchroniser; the first stage feeds only the second.
    logic [N-1:0] pad_s1;
    logic [N-1:0] pad_s2;
    always_ff @(posedge clk_i) begin
        pad_s1 <= pad_in_i;
        pad_s2 <= pad_s1;
    end
    assign periph_in_o = pad_s2;

    // Register state.
    logic [N-1:0] own, next_own;
    logic [N-1:0] drv, next_drv;
    logic [N-1:0] lvl, next_lvl;
    logic [N-1:0] dwm, next_dwm;
    logic [N-1:0] odr, next_odr;
    logic [N-1:0] puo, next_puo;
    logic [N-1:0] pu_on, next_pu_on;
    logic [N-1:0] chb, next_chb;
    logic [N-1:0] emsk, next_emsk;
    logic [N-1:0] evt, next_evt;
    logic [N-1:0] pin, next_pin;
    logic clk_on, next_clk_on;
    logic ack, next_ack;
    pio_pkg::word_t rdat, next_rdat;
    logic [N-1:0] pad_out, next_pad_out;
    logic [N-1:0] pad_oe_n, next_pad_oe_n;
    logic irq, next_irq;
    logic [N-1:0] chg;
    logic req;
    logic wr;
    logic rd_evt;
    pio_pkg::word_t wd;

    // A request is taken on the first edge it is seen and acked the next cycle.
    assign req = cyc_i & stb_i & ~ack;
    assign wr = req & we_i;
    assign rd_evt = req & ~we_i & (adr_i == `PIO_EVT_STATUS);

    // Write data gated by the byte lanes.
    always_comb begin
        wd = `PIO_RST_ZERO;
        for (int b = 0; b < 4; b++) begin
            wd[b*8 +: 8] = sel_i[b] ? dat_i[b*8 +: 8] : 8'h00;
        end
    end

    // Input changes exist only while the sampling clock runs.
    assign chg = clk_on ? (pad_s2 ^ pin) : '0;

    // Next values of the configuration registers and the pull-up enable.
    always_comb begin
        next_own = own;
        next_drv = drv;
        next_lvl = lvl;
        next_dwm = dwm;
        next_odr = odr;
        next_puo = puo;
        next_chb = chb;
        next_emsk = emsk;
        next_clk_on = clk_on;
        if (wr) begin
            // Set and clear writes touch only the lines with a 1 bit.
            unique case (adr_i)
                `PIO_OWN_TAKE: next_own = own | (wd[N-1:0] & MUXED);
                `PIO_OWN_RELEASE: next_own = own & ~(wd[N-1:0] & MUXED);
                `PIO_DRV_ON: next_drv = drv | wd[N-1:0];
                `PIO_DRV_OFF: next_drv = drv & ~wd[N-1:0];
                `PIO_LVL_HIGH: next_lvl = lvl | wd[N-1:0];
                `PIO_LVL_LOW: next_lvl = lvl & ~wd[N-1:0];
                `PIO_LVL_STATUS: begin
                    next_lvl = (lvl & ~dwm) | (dat_i[N-1:0] & dwm);
                end
                `PIO_DW_UNMASK: next_dwm = dwm | wd[N-1:0];
                `PIO_DW_MASK: next_dwm = dwm & ~wd[N-1:0];
                `PIO_OD_ON: next_odr = odr | wd[N-1:0];
                `PIO_OD_OFF: next_odr = odr & ~wd[N-1:0];
                `PIO_PU_OFF: next_puo = puo | wd[N-1:0];
                `PIO_PU_ON: next_puo = puo & ~wd[N-1:0];
                `PIO_PA_CHOOSE: next_chb = chb & ~(wd[N-1:0] & MUXED);
                `PIO_PB_CHOOSE: next_chb = chb | (wd[N-1:0] & MUXED);
                `PIO_EVT_UNMASK: next_emsk = emsk | wd[N-1:0];
                `PIO_EVT_MASK: next_emsk = emsk & ~wd[N-1:0];
                `PIO_CLK_CTRL: begin
                    if (sel_i[0]) begin
                        next_clk_on = dat_i[`PIO_CLK_ON_BIT];
                    end
                end
                default: ;
            endcase
        end
        // The pad pull-up enable is kept as a register of its own, the inverse of the status.
        next_pu_on = ~next_puo;
    end

    // Sampling, change events, interrupt and bus answer.
    always_comb begin
        // Pin status only follows the pad while the clock runs.
        next_pin = clk_on ? pad_s2 : pin;
        // A change in the read cycle survives the clear.
        next_evt = (rd_evt ? '0 : evt) | chg;
        next_irq = clk_on & (|(evt & emsk));
        next_ack = req;
        next_rdat = `PIO_RST_ZERO;
        if (req && !we_i) begin
            unique case (adr_i)
                `PIO_OWN_STATUS: next_rdat[N-1:0] = own;
                `PIO_DRV_STATUS: next_rdat[N-1:0] = drv;
                `PIO_LVL_STATUS: next_rdat[N-1:0] = lvl;
                `PIO_PIN_STATUS: next_rdat[N-1:0] = pin;
                `PIO_EVT_MASK_STATUS: next_rdat[N-1:0] = emsk;
                `PIO_EVT_STATUS: next_rdat[N-1:0] = evt;
                `PIO_OD_STATUS: next_rdat[N-1:0] = odr;
                `PIO_PU_STATUS: next_rdat[N-1:0] = puo;
                `PIO_CHOICE_STATUS: next_rdat[N-1:0] = chb;
                `PIO_DW_MASK_STATUS: next_rdat[N-1:0] = dwm;
                `PIO_CLK_CTRL: next_rdat[`PIO_CLK_ON_BIT] = clk_on;
                default: ;
            endcase
        end
    end

    // Pad drive: owner picks the source, choice picks A or B, open drain never drives high.
    always_comb begin
        logic [N-1:0] src_lvl;
        logic [N-1:0] src_oe;
        src_lvl = '0;
        src_oe = '0;
        for (int i = 0; i < N; i++) begin
            if (own[i]) begin
                src_lvl[i] = lvl[i];
                src_oe[i] = drv[i];
            end else if (chb[i]) begin
                src_lvl[i] = pb_out_i[i];
                src_oe[i] = pb_oe_i[i];
            end else begin
                src_lvl[i] = pa_out_i[i];
                src_oe[i] = pa_oe_i[i];
            end
        end
        // Open drain turns a high into a release for either source.
        next_pad_out = src_lvl & ~odr;
        next_pad_oe_n = ~(src_oe & ~(odr & src_lvl));
    end

    // All state registers but the pad synchroniser; configuration needs no sampling clock.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            own <= OWN_RST;
            drv <= '0;
            lvl <= '0;
            dwm <= '0;
            odr <= '0;
            puo <= '0;
            pu_on <= '1;
            chb <= '0;
            emsk <= '0;
            evt <= '0;
            pin <= '0;
            clk_on <= 1'b0;
            ack <= 1'b0;
            rdat <= `PIO_RST_ZERO;
            pad_out <= '0;
            pad_oe_n <= '1;
            irq <= 1'b0;
        end else begin
            own <= next_own;
            drv <= next_drv;
            lvl <= next_lvl;
            dwm <= next_dwm;
            odr <= next_odr;
            puo <= next_puo;
            pu_on <= next_pu_on;
            chb <= next_chb;
            emsk <= next_emsk;
            evt <= next_evt;
            pin <= next_pin;
            clk_on <= next_clk_on;
            ack <= next_ack;
            rdat <= next_rdat;
            pad_out <= next_pad_out;
            pad_oe_n <= next_pad_oe_n;
            irq <= next_irq;
        end
    end

    // Outputs come straight from the registers.
    assign ack_o = ack;
    assign dat_o = rdat;
    assign pad_out_o = pad_out;
    assign pad_oe_n_o = pad_oe_n;
    assign pullup_on_o = pu_on;
    assign irq_o = irq;

    // Checks on the block's own outputs and state.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence write_to(logic [`PIO_ADDR_W-1:0] a);
        cyc_i && stb_i && we_i && !ack && adr_i == a;
    endsequence

    sequence read_evt_taken;
        cyc_i && stb_i && !we_i && !ack && adr_i == `PIO_EVT_STATUS;
    endsequence

    sequence full_write(logic [`PIO_ADDR_W-1:0] a);
        write_to(a) ##0 sel_i == 4'hF;
    endsequence

    pullup_reset_a: assert property ($fell(rst_i) |-> puo == '0)
        else $error("pull-up status not zero after reset");

    owner_fixed_a: assert property ((own & ~MUXED) == ~MUXED)
        else $error("line without peripheral lost controller ownership");

    od_no_high_a: assert property (
        ((~pad_oe_n_o) & pad_out_o & $past(odr)) == '0)
        else $error("open drain line driven high");

    clk_off_quiet_a: assert property (!clk_on |=> (evt & ~$past(evt)) == '0)
        else $error("event raised with sampling clock off");

    evt_clear_a: assert property (read_evt_taken |=> (evt & ~$past(chg)) == '0)
        else $error("event status not cleared by read");

    dw_mask_a: assert property (
        write_to(`PIO_LVL_STATUS) |=> ((lvl ^ $past(lvl)) & ~$past(dwm)) == '0)
        else $error("masked output level bit changed");

    bus_ack_a: assert property (cyc_i && stb_i && !ack |=> ack_o ##1 !ack_o)
        else $error("bus acknowledge not one cycle");

    periph_a_drive_a: assert property (
        !rst_i |=> ((pad_out_o ^ $past(pa_out_i)) & $past(~own & ~chb & ~odr)) == '0)
        else $error("peripheral A level not on pad");

    irq_follow_a: assert property (
        !rst_i |=> irq_o == ($past(clk_on) && |($past(evt & emsk))))
        else $error("interrupt does not follow unmasked events");

    pin_hold_a: assert property (!clk_on |=> $stable(pin))
        else $error("pin status moved with sampling clock off");

    pu_write_a: assert property (
        full_write(`PIO_PU_OFF) |=> (puo & $past(dat_i[N-1:0])) == $past(dat_i[N-1:0]))
        else $error("pull-up off write did not set status");

    pu_on_write_a: assert property (
        full_write(`PIO_PU_ON) |=> (puo & $past(dat_i[N-1:0])) == '0)
        else $error("pull-up on write did not clear status");

    own_take_a: assert property (
        full_write(`PIO_OWN_TAKE) |=> (~own & $past(dat_i[N-1:0])) == '0)
        else $error("take write did not give the line to the controller");

    own_release_a: assert property (
        full_write(`PIO_OWN_RELEASE) |=> (own & $past(dat_i[N-1:0]) & MUXED) == '0)
        else $error("release write did not hand the line to a peripheral");

    choice_a_write_a: assert property (
        full_write(`PIO_PA_CHOOSE) |=> (chb & $past(dat_i[N-1:0])) == '0)
        else $error("A choose write did not clear the choice bit");

    choice_b_write_a: assert property (
        full_write(`PIO_PB_CHOOSE) |=> (~chb & $past(dat_i[N-1:0]) & MUXED) == '0)
        else $error("B choose write did not set the choice bit");

    choice_fixed_a: assert property ((chb & ~MUXED) == '0)
        else $error("line without peripheral took a peripheral choice");

    drv_on_write_a: assert property (
        full_write(`PIO_DRV_ON) |=> (~drv & $past(dat_i[N-1:0])) == '0)
        else $error("drive on write did not set drive status");

    drv_off_write_a: assert property (
        full_write(`PIO_DRV_OFF) |=> (drv & $past(dat_i[N-1:0])) == '0)
        else $error("drive off write did not clear drive status");

    lvl_high_write_a: assert property (
        full_write(`PIO_LVL_HIGH) |=> (~lvl & $past(dat_i[N-1:0])) == '0)
        else $error("level high write did not set output level");

    lvl_low_write_a: assert property (
        full_write(`PIO_LVL_LOW) |=> (lvl & $past(dat_i[N-1:0])) == '0)
        else $error("level low write did not clear output level");

    dw_unmask_write_a: assert property (
        full_write(`PIO_DW_UNMASK) |=> (~dwm & $past(dat_i[N-1:0])) == '0)
        else $error("unmask write did not set direct write mask");

    od_on_write_a: assert property (
        full_write(`PIO_OD_ON) |=> (~odr & $past(dat_i[N-1:0])) == '0)
        else $error("open drain on write did not set status");

    mask_reset_a: assert property ($fell(rst_i) |-> dwm == '0)
        else $error("direct write mask not zero after reset");

    od_reset_a: assert property ($fell(rst_i) |-> odr == '0)
        else $error("open drain status not zero after reset");

    choice_reset_a: assert property ($fell(rst_i) |-> chb == '0)
        else $error("peripheral choice not zero after reset");

    owner_reset_a: assert property ($fell(rst_i) |-> own == OWN_RST)
        else $error("ownership not at its integration value after reset");

    periph_b_drive_a: assert property (
        !rst_i |=> ((pad_out_o ^ $past(pb_out_i)) & $past(~own & chb & ~odr)) == '0)
        else $error("peripheral B level not on pad");

    periph_a_oe_a: assert property (
        !rst_i |=> ((pad_oe_n_o ^ ~$past(pa_oe_i)) & $past(~own & ~chb & ~odr)) == '0)
        else $error("peripheral A drive enable not on pad");

    owner_drive_a: assert property (
        !rst_i |=> ((pad_oe_n_o ^ ~$past(drv)) & $past(own & ~odr)) == '0)
        else $error("controller drive enable not on pad");

    owner_level_a: assert property (
        !rst_i |=> ((pad_out_o ^ $past(lvl)) & $past(own & ~odr)) == '0)
        else $error("controller output level not on pad");

    periph_sync_a: assert property (##2 periph_in_o == $past(pad_in_i, 2))
        else $error("peripheral input does not follow the pin");

    evt_set_a: assert property (chg != '0 |=> (evt & $past(chg)) == $past(chg))
        else $error("input change did not set its event bit");

    clk_off_irq_a: assert property (!clk_on |=> !irq_o)
        else $error("interrupt raised with sampling clock off");
endmodule : parallel_io_line_controller

// [rtl/pio_params.svh]
// Register offsets, reset values and field positions of the I/O line controller.
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH
`define PIO_ADDR_W 8
`define PIO_OWN_TAKE 8'h00
`define PIO_OWN_RELEASE 8'h04
`define PIO_OWN_STATUS 8'h08
`define PIO_DRV_ON 8'h10
`define PIO_DRV_OFF 8'h14
`define PIO_DRV_STATUS 8'h18
`define PIO_LVL_HIGH 8'h30
`define PIO_LVL_LOW 8'h34
`define PIO_LVL_STATUS 8'h38
`define PIO_PIN_STATUS 8'h3C
`define PIO_EVT_UNMASK 8'h40
`define PIO_EVT_MASK 8'h44
`define PIO_EVT_MASK_STATUS 8'h48
`define PIO_EVT_STATUS 8'h4C
`define PIO_OD_ON 8'h50
`define PIO_OD_OFF 8'h54
`define PIO_OD_STATUS 8'h58
`define PIO_PU_OFF 8'h60
`define PIO_PU_ON 8'h64
`define PIO_PU_STATUS 8'h68
`define PIO_PA_CHOOSE 8'h70
`define PIO_PB_CHOOSE 8'h74
`define PIO_CHOICE_STATUS 8'h78
`define PIO_DW_UNMASK 8'hA0
`define PIO_DW_MASK 8'hA4
`define PIO_DW_MASK_STATUS 8'hA8
`define PIO_CLK_CTRL 8'hB0
`define PIO_CLK_ON_BIT 0
`define PIO_RST_ZERO 32'h0000_0000
`endif

// [rtl/pio_pkg.sv]
// Shared types of the I/O line controller.
`include "pio_params.svh"
package pio_pkg;
    typedef logic [31:0] word_t;
    typedef logic [`PIO_ADDR_W-1:0] offset_t;
endpackage : pio_pkg

// [bench/pio_far_side.sv]
// Far side of the I/O lines: pads with pull-ups and external drivers.
module pio_far_side #(
    parameter int N = 32
) (
    input wire logic clk_i, // System clock.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic [N-1:0] pad_out_i, // Level from the controller.
    input wire logic [N-1:0] pad_oe_n_i, // Drive enable, low drives.
    input wire logic [N-1:0] pullup_on_i, // Internal pull-up per line.
    input wire logic [N-1:0] ext_en_i, // External device drives the line.
    input wire logic [N-1:0] ext_val_i, // Level of the external device.
    output logic [N-1:0] pad_o // Resolved line level.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [N-1:0] float_q;
    logic [N-1:0] next_float_q;

    // A floating line flips every cycle, so it never passes for a stable level.
    always_comb begin
        next_float_q = ~float_q;
    end

    // Registers the floating pattern.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            float_q <= '0;
        end else begin
            float_q <= next_float_q;
        end
    end

    // The pad driver wins, then an external device, then the pull-up.
    assign pad_o = (~pad_oe_n_i & pad_out_i) | (pad_oe_n_i & ext_en_i & ext_val_i)
        | (pad_oe_n_i & ~ext_en_i & (pullup_on_i | float_q));
endmodule : pio_far_side

// [bench/tb_top.sv]
// Self-checking testbench of the I/O line controller.
`include "pio_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        pio_pkg::offset_t wa;
        pio_pkg::word_t wd;
        pio_pkg::offset_t ra;
        pio_pkg::word_t exp;
    } row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    pio_pkg::offset_t adr_i = '0;
    logic [3:0] sel_i = 4'h0;
    pio_pkg::word_t dat_i = '0;
    pio_pkg::word_t dat_o;
    logic ack_o;
    logic [31:0] pad_in_i;
    logic [31:0] pad_out_o;
    logic [31:0] pad_oe_n_o;
    logic [31:0] pullup_on_o;
    logic [31:0] pa_out_i = 32'h5555_5555;
    logic [31:0] pa_oe_i = 32'h000F_0000;
    logic [31:0] pb_out_i = 32'hAAAA_AAAA;
    logic [31:0] pb_oe_i = 32'hFF00_FF00;
    logic [31:0] periph_in_o;
    logic irq_o;
    logic [31:0] ext_en = '0;
    logic [31:0] ext_val = '0;
    int miscompares = 0;
    int n_checks = 0;
    row_t rows[18] = '{
        '{`PIO_PU_OFF, 32'h0002_00F0, `PIO_PU_STATUS, 32'h0002_00F0},
        '{`PIO_PU_ON, 32'h0000_0030, `PIO_PU_STATUS, 32'h0002_00C0},
        '{`PIO_OWN_RELEASE, 32'hFFFF_FFFF, `PIO_OWN_STATUS, 32'h0000_00FF},
        '{`PIO_OWN_TAKE, 32'h0000_0F00, `PIO_OWN_STATUS, 32'h0000_0FFF},
        '{`PIO_PB_CHOOSE, 32'hFFFF_00FF, `PIO_CHOICE_STATUS, 32'hFFFF_0000},
        '{`PIO_PA_CHOOSE, 32'h00FF_0000, `PIO_CHOICE_STATUS, 32'hFF00_0000},
        '{`PIO_DRV_ON, 32'h0000_FFFF, `PIO_DRV_STATUS, 32'h0000_FFFF},
        '{`PIO_DRV_OFF, 32'h0000_F000, `PIO_DRV_STATUS, 32'h0000_0FFF},
        '{`PIO_DRV_STATUS, 32'h0000_0000, `PIO_DRV_STATUS, 32'h0000_0FFF},
        '{`PIO_LVL_HIGH, 32'h0000_10AA, `PIO_LVL_STATUS, 32'h0000_10AA},
        '{`PIO_LVL_LOW, 32'h0000_1082, `PIO_LVL_STATUS, 32'h0000_0028},
        '{`PIO_LVL_STATUS, 32'hFFFF_FFFF, `PIO_LVL_STATUS, 32'h0000_0028},
        '{`PIO_DW_UNMASK, 32'h0000_000F, `PIO_DW_MASK_STATUS, 32'h0000_000F},
        '{`PIO_LVL_STATUS, 32'hFFFF_FFF5, `PIO_LVL_STATUS, 32'h0000_0025},
        '{`PIO_DW_MASK, 32'h0000_0003, `PIO_DW_MASK_STATUS, 32'h0000_000C},
        '{`PIO_OD_ON, 32'h8000_00F0, `PIO_OD_STATUS, 32'h8000_00F0},
        '{`PIO_OD_OFF, 32'h0000_00C0, `PIO_OD_STATUS, 32'h8000_0030},
        '{8'h0C, 32'hFFFF_FFFF, 8'h0C, 32'h0000_0000}
    };

    parallel_io_line_controller #(
        .N(32),
        .HAS_PERIPH(32'hFFFF_FF00),
        .OWNER_RESET(32'h0FFF_FFFF)
    ) i_parallel_io_line_controller (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
        .pullup_on_o(pullup_on_o), .pa_out_i(pa_out_i), .pa_oe_i(pa_oe_i),
        .pb_out_i(pb_out_i), .pb_oe_i(pb_oe_i), .periph_in_o(periph_in_o), .irq_o(irq_o)
    );

    pio_far_side #(.N(32)) i_pio_far_side (
        .clk_i(clk_i), .rst_i(rst_i), .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
        .pullup_on_i(pullup_on_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad_in_i)
    );

    // Free-running 125 MHz clock.
    always #4 clk_i = ~clk_i;

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input pio_pkg::word_t got, input pio_pkg::word_t exp, input string s);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, s, got, exp);
        end
    endtask : chk

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input pio_pkg::offset_t a, input pio_pkg::word_t d,
                      output pio_pkg::word_t q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (ack_o !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: bus acknowledge timed out", $time);
            report_and_stop();
        end
    endtask : wb

    task automatic wr(input pio_pkg::offset_t a, input pio_pkg::word_t d);
        pio_pkg::word_t q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input pio_pkg::offset_t a, input pio_pkg::word_t exp);
        pio_pkg::word_t q;
        wb(1'b0, a, '0, q);
        chk(q, exp, "register read");
    endtask : rd

    // Main sequence: table first, then pins, events and a second reset.
    initial begin
        int n;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, rows[i].exp);
        end
        repeat (3) @(posedge clk_i);
        chk(pad_oe_n_o, 32'h80F0_F020, "pad enables");
        chk(pad_out_o & ~32'h80F0_F020, 32'h2A05_0005, "pad levels");
        chk(pullup_on_o, 32'hFFFD_FF3F, "pull-ups");
        chk(periph_in_o, 32'hAAF5_F025, "peripheral inputs");
        rd(`PIO_PIN_STATUS, 32'h0000_0000);
        wr(`PIO_CLK_CTRL, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        rd(`PIO_PIN_STATUS, 32'hAAF5_F025);
        wr(`PIO_EVT_STATUS + 8'h00, 32'h0000_0000);
        rd(`PIO_EVT_STATUS, 32'hAAF5_F025);
        rd(`PIO_EVT_STATUS, 32'h0000_0000);
        wr(`PIO_EVT_UNMASK, 32'h0000_1000);
        chk({31'h0, irq_o}, 32'h0, "interrupt idle");
        ext_en <= 32'h0000_1000;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (irq_o !== 1'b1 && n < 10);
        chk({31'h0, irq_o}, 32'h1, "interrupt raised");
        if (irq_o !== 1'b1) begin
            report_and_stop();
        end
        rd(`PIO_EVT_STATUS, 32'h0000_1000);
        @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0, "interrupt cleared");
        wr(`PIO_CLK_CTRL, 32'h0000_0000);
        ext_en <= 32'h0000_0000;
        repeat (4) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0, "interrupt with clock off");
        rd(`PIO_PIN_STATUS, 32'hAAF5_E025);
        rd(`PIO_EVT_STATUS, 32'h0000_0000);
        chk(periph_in_o, 32'hAAF5_F025, "peripheral inputs");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`PIO_PU_STATUS, 32'h0000_0000);
        rd(`PIO_OWN_STATUS, 32'h0FFF_FFFF);
        rd(`PIO_CHOICE_STATUS, 32'h0000_0000);
        rd(`PIO_DW_MASK_STATUS, 32'h0000_0000);
        rd(`PIO_OD_STATUS, 32'h0000_0000);
        rd(`PIO_DRV_STATUS, 32'h0000_0000);
        chk(pad_oe_n_o & 32'h0FFF_FFFF, 32'h0FFF_FFFF, "pads released");
        report_and_stop();
    end
endmodule : tb_top
